/* File: hdl/acb_pkg.sv */
// constants shared by the channel configuration bank
package acb_pkg;

	// register offsets on the control port
	localparam logic [7:0] OFS_OVLD_MUTE  = 8'h4b;
	localparam logic [7:0] OFS_PWR_TUNE   = 8'h4e;
	localparam logic [7:0] OFS_CH1_INPUT  = 8'h50;
	localparam logic [7:0] OFS_CH1_VOLUME = 8'h52;
	localparam logic [7:0] OFS_CH1_TRIM   = 8'h53;
	localparam logic [7:0] OFS_CH1_PHASE  = 8'h54;

	// reset values
	localparam logic [7:0] RST_OVLD_MUTE  = 8'h00;
	localparam logic [7:0] RST_PWR_TUNE   = 8'h00;
	localparam logic [7:0] RST_CH1_INPUT  = 8'h00;
	localparam logic [7:0] RST_CH1_VOLUME = 8'ha1;
	localparam logic [7:0] RST_CH1_TRIM   = 8'h80;
	localparam logic [7:0] RST_CH1_PHASE  = 8'h00;

	// writable bits; reserved bits are held at zero
	localparam logic [7:0] MSK_OVLD_MUTE  = 8'h18;
	localparam logic [7:0] MSK_PWR_TUNE   = 8'hf4;
	localparam logic [7:0] MSK_CH1_INPUT  = 8'hcf;
	localparam logic [7:0] MSK_CH1_VOLUME = 8'hff;
	localparam logic [7:0] MSK_CH1_TRIM   = 8'hf0;
	localparam logic [7:0] MSK_CH1_PHASE  = 8'hff;

	// field positions
	localparam int BIT_CH1_OVLD   = 4;
	localparam int BIT_CH2_OVLD   = 3;
	localparam int BIT_MOD_HALVE  = 7;
	localparam int BIT_CIC_ORDER  = 6;
	localparam int BIT_FIR_SKIP   = 5;
	localparam int BIT_DEM_DOUBLE = 4;
	localparam int BIT_LOW_POWER  = 2;
	localparam int LSB_SOURCE     = 6;
	localparam int LSB_COUPLING   = 2;
	localparam int BIT_RANGE      = 1;
	localparam int BIT_BANDWIDTH  = 0;
	localparam int LSB_TRIM       = 4;
	localparam int LSB_DELAY      = 2;
	localparam int LSB_SCOPE      = 0;

	// gain arithmetic: codes to tenths of a dB, octaves of 6.0 dB
	localparam logic [11:0] VOL_UNITY_CODE = 12'h0a1;
	localparam logic [11:0] TRIM_ZERO_CODE = 12'h008;
	localparam logic [11:0] TENTH_BIAS     = 12'h384;
	localparam logic [10:0] TENTH_OCTAVE   = 11'h03c;
	localparam logic [4:0]  SHIFT_UNITY    = 5'h1e;

	// phase delay line depth in modulator cycles
	localparam int DELAY_DEPTH = 64;
	localparam int DELAY_AW    = 6;

	// where the phase delay applies
	typedef enum logic [1:0] {
		SCOPE_BOTH    = 2'b00,
		SCOPE_ANALOG  = 2'b01,
		SCOPE_DIGITAL = 2'b10,
		SCOPE_RSVD    = 2'b11
	} acb_scope_e;

endpackage

/* File: hdl/acb_delay_mem.sv */
// small delay memory for the modulator bit stream, registered read
`timescale 1ns/100ps
module acb_delay_mem
(
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         nrst_i,
	// write side
	input  wire logic                         wr_i,
	input  wire logic [acb_pkg::DELAY_AW-1:0] waddr_i,
	input  wire logic                         wdata_i,
	// read side
	input  wire logic [acb_pkg::DELAY_AW-1:0] raddr_i,
	output logic                              rdata_o
);

	logic [acb_pkg::DELAY_DEPTH-1:0] mem;

	// cleared at reset so a long delay never plays out unknown bits
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mem     <= '0;
			rdata_o <= 1'b0;
		end
		else
		begin
			if (wr_i)
				mem[waddr_i] <= wdata_i;
			rdata_o <= mem[raddr_i];
		end
	end

endmodule

/* File: hdl/acb_gain.sv */
// volume and trim gain stage for one sample stream
`timescale 1ns/100ps
module acb_gain
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// incoming sample and live settings
	input  wire logic [23:0] smp_i,
	input  wire logic        valid_i,
	input  wire logic [7:0]  vol_code_i,
	input  wire logic [3:0]  trim_i,
	input  wire logic        mute_i,
	// scaled sample
	output logic      [23:0] smp_o,
	output logic             valid_o
);

	// 2^(k/12) in Q1.15 for k = 0..11, one 0.5 dB step each
	function automatic logic [15:0] half_db_mant(input logic [3:0] k);
		case (k)
			4'h0:    half_db_mant = 16'h8000;
			4'h1:    half_db_mant = 16'h879c;
			4'h2:    half_db_mant = 16'h8fad;
			4'h3:    half_db_mant = 16'h9838;
			4'h4:    half_db_mant = 16'ha145;
			4'h5:    half_db_mant = 16'haadc;
			4'h6:    half_db_mant = 16'hb505;
			4'h7:    half_db_mant = 16'hbfc9;
			4'h8:    half_db_mant = 16'hcb30;
			4'h9:    half_db_mant = 16'hd745;
			4'ha:    half_db_mant = 16'he412;
			4'hb:    half_db_mant = 16'hf1a2;
			default: half_db_mant = 16'h8000;
		endcase
	endfunction

	logic signed [11:0] tenths;
	logic        [10:0] biased;
	logic        [4:0]  octave;
	logic        [5:0]  rem;
	logic        [15:0] base;
	logic        [2:0]  frac;
	logic        [16:0] mant;
	logic signed [41:0] prod;
	logic signed [41:0] scaled;
	logic        [23:0] next_smp;

	// codes to tenths of a dB: volume 0.5 dB steps, trim 0.1 dB
	assign tenths = 12'(5 * ($signed({4'h0, vol_code_i})
		- $signed(acb_pkg::VOL_UNITY_CODE)))
		+ $signed({8'h00, trim_i})
		- $signed(acb_pkg::TRIM_ZERO_CODE);
	assign biased = 11'(tenths + $signed(acb_pkg::TENTH_BIAS));
	assign octave = 5'(biased / acb_pkg::TENTH_OCTAVE);
	assign rem    = 6'(biased % acb_pkg::TENTH_OCTAVE);
	// tenths between half steps by a 1.17 % linear nudge each
	assign base   = half_db_mant(4'(rem / 6'd5));
	assign frac   = 3'(rem % 6'd5);
	assign mant   = {1'b0, base} + 17'((32'(base) * frac * 3) >> 8);
	assign prod   = $signed(smp_i) * $signed({1'b0, mant});
	assign scaled = prod >>> (acb_pkg::SHIFT_UNITY - octave);

	// saturate, and zero the sample outright when muted
	assign next_smp = mute_i ? 24'h00_0000
		: (scaled > 42'sh7f_ffff) ? 24'h7f_ffff
		: (scaled < -42'sh80_0000) ? 24'h80_0000
		: scaled[23:0];

	// settings are taken only with the sample they scale
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			smp_o   <= 24'h00_0000;
			valid_o <= 1'b0;
		end
		else
		begin
			valid_o <= valid_i;
			if (valid_i)
				smp_o <= next_smp;
		end
	end

endmodule

/* File: hdl/acb_bank.sv */
// channel 1 configuration bank with its digital channel controls
`timescale 1ns/100ps
module acb_bank
(
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        NRST_I,
	// register port from the control interface
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [7:0]  REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic      [7:0]  REG_RDATA_O,
	output logic             REG_HIT_O,
	// overload recovery state of both converters
	input  wire logic        OVLD1_I,
	input  wire logic        OVLD2_I,
	// channel 1 decimated sample stream
	input  wire logic [23:0] SMP_I,
	input  wire logic        SMP_VALID_I,
	output logic      [23:0] SMP_O,
	output logic             SMP_VALID_O,
	// channel 1 modulator bit stream
	input  wire logic        MOD_TICK_I,
	input  wire logic        MOD_BIT_I,
	output logic             MOD_STROBE_O,
	output logic             MOD_BIT_O,
	// channel 2 silence request
	output logic             CH2_SILENCE_O,
	// decimation and power tuning controls
	output logic             CIC_ORDER_O,
	output logic             FIR_SKIP_O,
	output logic             DEM_DOUBLE_O,
	output logic             LOW_POWER_FILTER_O,
	// channel 1 analog front end controls
	output logic      [1:0]  CH1_SOURCE_O,
	output logic      [1:0]  CH1_COUPLING_O,
	output logic             CH1_RANGE_O,
	output logic             CH1_BANDWIDTH_O,
	output logic      [5:0]  CH1_ANA_DELAY_O
);

	// address decode for the hit flag; the write and read paths compare offsets on their own
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == acb_pkg::OFS_OVLD_MUTE)
			|| (a == acb_pkg::OFS_PWR_TUNE)
			|| (a == acb_pkg::OFS_CH1_INPUT)
			|| (a == acb_pkg::OFS_CH1_VOLUME)
			|| (a == acb_pkg::OFS_CH1_TRIM)
			|| (a == acb_pkg::OFS_CH1_PHASE);
	endfunction

	logic [7:0] ovld_mute;
	logic [7:0] pwr_tune;
	logic [7:0] ch1_input;
	logic [7:0] ch1_volume;
	logic [7:0] ch1_trim;
	logic [7:0] ch1_phase;

	// register file writes
	logic wr_ovld;
	logic wr_pwr;
	logic wr_input;
	logic wr_volume;
	logic wr_trim;
	logic wr_phase;

	assign wr_ovld   = REG_WR_I && (REG_ADDR_I == acb_pkg::OFS_OVLD_MUTE);
	assign wr_pwr    = REG_WR_I && (REG_ADDR_I == acb_pkg::OFS_PWR_TUNE);
	assign wr_input  = REG_WR_I && (REG_ADDR_I == acb_pkg::OFS_CH1_INPUT);
	assign wr_volume = REG_WR_I && (REG_ADDR_I == acb_pkg::OFS_CH1_VOLUME);
	assign wr_trim   = REG_WR_I && (REG_ADDR_I == acb_pkg::OFS_CH1_TRIM);
	assign wr_phase  = REG_WR_I && (REG_ADDR_I == acb_pkg::OFS_CH1_PHASE);

	// masks keep reserved bits at zero whatever software writes
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			ovld_mute  <= acb_pkg::RST_OVLD_MUTE;
			pwr_tune   <= acb_pkg::RST_PWR_TUNE;
			ch1_input  <= acb_pkg::RST_CH1_INPUT;
			ch1_volume <= acb_pkg::RST_CH1_VOLUME;
			ch1_trim   <= acb_pkg::RST_CH1_TRIM;
			ch1_phase  <= acb_pkg::RST_CH1_PHASE;
		end
		else
		begin
			if (wr_ovld)
				ovld_mute <= REG_WDATA_I & acb_pkg::MSK_OVLD_MUTE;
			if (wr_pwr)
				pwr_tune <= REG_WDATA_I & acb_pkg::MSK_PWR_TUNE;
			if (wr_input)
				ch1_input <= REG_WDATA_I & acb_pkg::MSK_CH1_INPUT;
			if (wr_volume)
				ch1_volume <= REG_WDATA_I & acb_pkg::MSK_CH1_VOLUME;
			if (wr_trim)
				ch1_trim <= REG_WDATA_I & acb_pkg::MSK_CH1_TRIM;
			if (wr_phase)
				ch1_phase <= REG_WDATA_I & acb_pkg::MSK_CH1_PHASE;
		end
	end

	// read mux, unmapped addresses answer zero
	logic [7:0] rd_mux;

	assign REG_HIT_O = is_mapped(REG_ADDR_I);
	assign rd_mux =
		(REG_ADDR_I == acb_pkg::OFS_OVLD_MUTE)  ? ovld_mute  :
		(REG_ADDR_I == acb_pkg::OFS_PWR_TUNE)   ? pwr_tune   :
		(REG_ADDR_I == acb_pkg::OFS_CH1_INPUT)  ? ch1_input  :
		(REG_ADDR_I == acb_pkg::OFS_CH1_VOLUME) ? ch1_volume :
		(REG_ADDR_I == acb_pkg::OFS_CH1_TRIM)   ? ch1_trim   :
		(REG_ADDR_I == acb_pkg::OFS_CH1_PHASE)  ? ch1_phase  : 8'h00;

	// read data held until the next read
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			REG_RDATA_O <= 8'h00;
		else if (REG_RD_I)
			REG_RDATA_O <= rd_mux;
	end

	// named fields
	logic             ch1_overload_silence_en;
	logic             ch2_overload_silence_en;
	logic             modulator_clock_halve;
	logic       [7:0] ch1_volume_code;
	logic       [3:0] ch1_trim_gain;
	logic       [5:0] ch1_phase_delay_cycles;
	acb_pkg::acb_scope_e phase_scope;

	assign ch1_overload_silence_en = ovld_mute[acb_pkg::BIT_CH1_OVLD];
	assign ch2_overload_silence_en = ovld_mute[acb_pkg::BIT_CH2_OVLD];
	assign modulator_clock_halve   = pwr_tune[acb_pkg::BIT_MOD_HALVE];
	assign ch1_volume_code         = ch1_volume;
	assign ch1_trim_gain  = ch1_trim[acb_pkg::LSB_TRIM +: 4];
	assign ch1_phase_delay_cycles = ch1_phase[acb_pkg::LSB_DELAY +: 6];
	assign phase_scope = acb_pkg::acb_scope_e'(
		ch1_phase[acb_pkg::LSB_SCOPE +: 2]);

	// control levels straight from register flip-flops
	assign CIC_ORDER_O        = pwr_tune[acb_pkg::BIT_CIC_ORDER];
	assign FIR_SKIP_O         = pwr_tune[acb_pkg::BIT_FIR_SKIP];
	assign DEM_DOUBLE_O       = pwr_tune[acb_pkg::BIT_DEM_DOUBLE];
	assign LOW_POWER_FILTER_O = pwr_tune[acb_pkg::BIT_LOW_POWER];
	assign CH1_SOURCE_O   = ch1_input[acb_pkg::LSB_SOURCE +: 2];
	assign CH1_COUPLING_O = ch1_input[acb_pkg::LSB_COUPLING +: 2];
	assign CH1_RANGE_O     = ch1_input[acb_pkg::BIT_RANGE];
	assign CH1_BANDWIDTH_O = ch1_input[acb_pkg::BIT_BANDWIDTH];

	// scope decides which path gets the delay; reserved means none
	logic       ana_delay_on;
	logic       dig_delay_on;
	logic [5:0] dig_delay;

	always_comb
	begin
		ana_delay_on = 1'b0;
		dig_delay_on = 1'b0;
		case (phase_scope)
			acb_pkg::SCOPE_BOTH:
			begin
				ana_delay_on = 1'b1;
				dig_delay_on = 1'b1;
			end
			acb_pkg::SCOPE_ANALOG:  ana_delay_on = 1'b1;
			acb_pkg::SCOPE_DIGITAL: dig_delay_on = 1'b1;
			default:
			begin
				ana_delay_on = 1'b0;
				dig_delay_on = 1'b0;
			end
		endcase
	end

	assign CH1_ANA_DELAY_O = ana_delay_on ? ch1_phase_delay_cycles
		: 6'h00;
	assign dig_delay = dig_delay_on ? ch1_phase_delay_cycles : 6'h00;

	// every other tick in halve mode gives half the modulator rate
	logic tick_phase;
	logic mod_en;

	assign mod_en = MOD_TICK_I && (!modulator_clock_halve || tick_phase);
	assign MOD_STROBE_O = mod_en;

	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			tick_phase <= 1'b0;
		else if (MOD_TICK_I)
			tick_phase <= !tick_phase;
	end

	// modulator stream delay line; one clock of latency at any delay
	logic [acb_pkg::DELAY_AW-1:0] wr_ptr;
	logic [acb_pkg::DELAY_AW-1:0] rd_ptr;
	logic                         mem_rdata;
	logic                         mod_en_d;
	logic                         bit_d;
	logic                         zero_delay_d;

	// difference wraps with the memory depth, so 63 still lands in range
	assign rd_ptr = wr_ptr - dig_delay;

	acb_delay_mem u_delay
	(
		.clk_i   (CLK_I),
		.nrst_i  (NRST_I),
		.wr_i    (mod_en),
		.waddr_i (wr_ptr),
		.wdata_i (MOD_BIT_I),
		.raddr_i (rd_ptr),
		.rdata_o (mem_rdata)
	);

	// pointer advances once per modulator cycle
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			wr_ptr <= '0;
		else if (mod_en)
			wr_ptr <= wr_ptr + 1'b1;
	end

	// strobe, bit and bypass choice trail by one clock like the memory,
	// so the output has the same latency at every delay setting
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			mod_en_d     <= 1'b0;
			bit_d        <= 1'b0;
			zero_delay_d <= 1'b1;
		end
		else
		begin
			mod_en_d     <= mod_en;
			bit_d        <= MOD_BIT_I;
			zero_delay_d <= (dig_delay == 6'h00);
		end
	end

	// delayed bit presented the clock after its modulator strobe
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			MOD_BIT_O <= 1'b0;
		else if (mod_en_d)
			MOD_BIT_O <= zero_delay_d ? bit_d : mem_rdata;
	end

	// channel 2 path lives elsewhere; only its silence request here
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			CH2_SILENCE_O <= 1'b0;
		else
			CH2_SILENCE_O <= ch2_overload_silence_en && OVLD2_I;
	end

	// mute when volume is zero or during enabled overload recovery
	logic ch1_mute;

	assign ch1_mute = (ch1_volume_code == 8'h00)
		|| (ch1_overload_silence_en && OVLD1_I);

	acb_gain u_gain
	(
		.clk_i      (CLK_I),
		.nrst_i     (NRST_I),
		.smp_i      (SMP_I),
		.valid_i    (SMP_VALID_I),
		.vol_code_i (ch1_volume_code),
		.trim_i     (ch1_trim_gain),
		.mute_i     (ch1_mute),
		.smp_o      (SMP_O),
		.valid_o    (SMP_VALID_O)
	);

endmodule

/* File: bench/acb_bank_chk.sv */
// port checker for the channel configuration bank
`timescale 1ns/100ps
module acb_bank_chk
(
	// clock and reset
	input wire logic        CLK_I,
	input wire logic        NRST_I,
	// register port
	input wire logic [7:0]  REG_ADDR_I,
	input wire logic [7:0]  REG_WDATA_I,
	input wire logic        REG_WR_I,
	input wire logic        REG_RD_I,
	input wire logic [7:0]  REG_RDATA_O,
	input wire logic        REG_HIT_O,
	// channel traffic
	input wire logic        OVLD1_I,
	input wire logic        OVLD2_I,
	input wire logic        SMP_VALID_I,
	input wire logic        SMP_VALID_O,
	input wire logic [23:0] SMP_O,
	input wire logic        MOD_TICK_I,
	input wire logic        MOD_STROBE_O,
	input wire logic        CH2_SILENCE_O,
	// control outputs
	input wire logic        CIC_ORDER_O,
	input wire logic        FIR_SKIP_O,
	input wire logic        DEM_DOUBLE_O,
	input wire logic        LOW_POWER_FILTER_O,
	input wire logic [1:0]  CH1_SOURCE_O,
	input wire logic [1:0]  CH1_COUPLING_O,
	input wire logic        CH1_RANGE_O,
	input wire logic        CH1_BANDWIDTH_O,
	input wire logic [5:0]  CH1_ANA_DELAY_O
);
	// shadow of the writable bits, kept from the write traffic alone
	logic [7:0] om, pt, ci, vol, ph;
	logic       phs;
	wire        mapped = REG_ADDR_I inside {8'h4b, 8'h4e, 8'h50, 8'h52,
		8'h53, 8'h54};

	// masked shadow writes
	always_ff @(posedge CLK_I or negedge NRST_I)
		if (!NRST_I)
		begin
			om <= 8'h00;
			pt <= 8'h00;
			ci <= 8'h00;
			vol <= 8'ha1;
			ph <= 8'h00;
		end
		else if (REG_WR_I)
			case (REG_ADDR_I)
				8'h4b: om <= REG_WDATA_I & 8'h18;
				8'h4e: pt <= REG_WDATA_I & 8'hf4;
				8'h50: ci <= REG_WDATA_I & 8'hcf;
				8'h52: vol <= REG_WDATA_I;
				8'h54: ph <= REG_WDATA_I;
				default: ;
			endcase

	// tick parity: in halve mode only the second tick of a pair counts
	always_ff @(posedge CLK_I or negedge NRST_I)
		if (!NRST_I)
			phs <= 1'b0;
		else if (MOD_TICK_I)
			phs <= !phs;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	// a read of an unmapped place, then zero data
	sequence s_miss;
		REG_RD_I && !mapped;
	endsequence
	// a sample taken while condition c holds
	sequence s_take(c);
		SMP_VALID_I && c;
	endsequence
	// a taken sample that must come out silent
	property p_silent(c);
		s_take(c) |=> SMP_VALID_O && SMP_O == 24'h00_0000;
	endproperty

	a_hit_map: assert property (REG_HIT_O == mapped)
		else $error("hit flag disagrees with address map");
	a_rd_unmapped: assert property (
		s_miss |=> REG_RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	a_vol_mute: assert property (p_silent(vol == 8'h00))
		else $error("volume zero did not silence");
	a_ovld_mute: assert property (p_silent(om[4] && OVLD1_I))
		else $error("overload did not silence channel 1");
	a_ch2_silence: assert property (
		CH2_SILENCE_O == $past(om[3] && OVLD2_I))
		else $error("channel 2 silence request wrong");
	a_tune_bits: assert property (
		{CIC_ORDER_O, FIR_SKIP_O, DEM_DOUBLE_O, LOW_POWER_FILTER_O}
		== {pt[6], pt[5], pt[4], pt[2]})
		else $error("tuning control outputs wrong");
	a_front_end: assert property (
		{CH1_SOURCE_O, CH1_COUPLING_O, CH1_RANGE_O, CH1_BANDWIDTH_O}
		== {ci[7:6], ci[3:0]})
		else $error("front end control outputs wrong");
	a_ana_delay: assert property (
		CH1_ANA_DELAY_O == (ph[1] ? 6'h00 : ph[7:2]))
		else $error("analog phase delay wrong");
	a_mod_halve: assert property (
		MOD_STROBE_O == (MOD_TICK_I && (!pt[7] || phs)))
		else $error("modulator strobe rate wrong");
endmodule

/* File: bench/test_acb_bank.sv */
// self-checking bench for the channel configuration bank
`timescale 1ns/100ps
module test_acb_bank;
	// stimulus
	logic        CLK_I = '0, NRST_I = '0, REG_WR_I = '0, REG_RD_I = '0;
	logic        OVLD1_I = '0, OVLD2_I = '0, SMP_VALID_I = '0;
	logic        MOD_TICK_I = '0, MOD_BIT_I = '0;
	logic [7:0]  REG_ADDR_I = '0, REG_WDATA_I = '0;
	logic [23:0] SMP_I = '0;
	// responses
	logic [7:0]  REG_RDATA_O;
	logic [23:0] SMP_O;
	logic [5:0]  CH1_ANA_DELAY_O;
	logic [1:0]  CH1_SOURCE_O, CH1_COUPLING_O;
	logic        REG_HIT_O, SMP_VALID_O, MOD_STROBE_O, MOD_BIT_O;
	logic        CH2_SILENCE_O, CIC_ORDER_O, FIR_SKIP_O, DEM_DOUBLE_O;
	logic        LOW_POWER_FILTER_O, CH1_RANGE_O, CH1_BANDWIDTH_O;
	// expectation queues, strobe history and register tables
	int          error_cnt = 0, tests_run = 0;
	logic [31:0] seed = 32'hc99a_c77d;
	logic [7:0]  rq[$];
	logic [23:0] sq[$];
	logic        mq[$], hist[$], phase = '0, rd_now, mod_now, mod_prev = '0;
	logic [23:0] x;
	logic [7:0]  ofs[7] = '{8'h4b, 8'h4e, 8'h50, 8'h52, 8'h53, 8'h54, 8'h51};
	logic [7:0]  rst[7] = '{8'h00, 8'h00, 8'h00, 8'ha1, 8'h80, 8'h00, 8'h00};
	logic [7:0]  msk[7] = '{8'h18, 8'hf4, 8'hcf, 8'hff, 8'hf0, 8'hff, 8'h00};

	// design under test
	acb_bank i_acb_bank (.CLK_I, .NRST_I, .REG_ADDR_I, .REG_WDATA_I,
		.REG_WR_I, .REG_RD_I, .REG_RDATA_O, .REG_HIT_O, .OVLD1_I, .OVLD2_I,
		.SMP_I, .SMP_VALID_I, .SMP_O, .SMP_VALID_O, .MOD_TICK_I, .MOD_BIT_I,
		.MOD_STROBE_O, .MOD_BIT_O, .CH2_SILENCE_O, .CIC_ORDER_O, .FIR_SKIP_O,
		.DEM_DOUBLE_O, .LOW_POWER_FILTER_O, .CH1_SOURCE_O, .CH1_COUPLING_O,
		.CH1_RANGE_O, .CH1_BANDWIDTH_O, .CH1_ANA_DELAY_O);

	// 100 MHz clock
	initial
		forever #5 CLK_I = ~CLK_I;

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task cyc();
		@(posedge CLK_I);
		#1;
	endtask

	task chk(input logic [23:0] g, e);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	// one compare task per kind of result
	task chk_rd(input logic [7:0] g, e);
		chk({16'h0000, g}, {16'h0000, e});
	endtask

	task chk_smp(input logic [23:0] g, e);
		chk(g, e);
	endtask

	task chk_bit(input logic g, e);
		chk({23'h00_0000, g}, {23'h00_0000, e});
	endtask

	task final_report();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one register access; a read notes the expected data
	task acc(input logic w, input logic [7:0] a, d);
		cyc();
		REG_ADDR_I = a;
		REG_WDATA_I = d;
		REG_WR_I = w;
		REG_RD_I = !w;
		if (!w)
			rq.push_back(d);
		cyc();
		REG_WR_I = 0;
		REG_RD_I = 0;
	endtask

	task smp(input logic [23:0] xi, e);
		cyc();
		SMP_I = xi;
		SMP_VALID_I = 1;
		sq.push_back(e);
		cyc();
		SMP_VALID_I = 0;
	endtask

	task gtest(input logic [7:0] v, input logic [3:0] t,
		input logic [23:0] xi, e);
		acc(1, 8'h52, v);
		acc(1, 8'h53, {t, 4'h0});
		smp(xi, e);
	endtask

	// modulator traffic; the history covers every strobe since reset
	task mod_run(input logic [5:0] n, input logic [1:0] sc, input logic h,
		input int cnt);
		logic [31:0] r;
		logic        st;
		int          k;
		acc(1, 8'h4e, {h, 7'h00});
		acc(1, 8'h54, {n, sc});
		k = sc[0] ? 0 : n;
		repeat (cnt)
		begin
			r = rnd();
			MOD_TICK_I = r[0] | r[1];
			MOD_BIT_I = r[2];
			st = MOD_TICK_I && (!h || phase);
			phase ^= MOD_TICK_I;
			if (st)
			begin
				hist.push_front(MOD_BIT_I);
				mq.push_back(hist.size() > k ? hist[k] : 1'b0);
			end
			cyc();
		end
		MOD_TICK_I = 0;
	endtask

	// strobes seen before the edge, results compared after it;
	// the delayed bit lands one clock after its strobe's edge
	always
	begin
		@(negedge CLK_I);
		rd_now = REG_RD_I;
		mod_now = mod_prev;
		mod_prev = MOD_STROBE_O;
		@(posedge CLK_I);
		#2;
		if (rd_now === 1'b1)
			chk_rd(REG_RDATA_O, rq.pop_front());
		if (SMP_VALID_O === 1'b1)
			chk_smp(SMP_O, sq.pop_front());
		if (mod_now === 1'b1)
			chk_bit(MOD_BIT_O, mq.pop_front());
	end

	// main sequence
	initial
	begin
		repeat (6) @(posedge CLK_I);
		#1 NRST_I = 1;
		for (int i = 0; i < 7; i++)
			acc(0, ofs[i], rst[i]);
		$display("reset values done");
		for (int i = 0; i < 7; i++)
		begin
			acc(1, ofs[i], 8'hff);
			acc(0, ofs[i], msk[i]);
			acc(1, ofs[i], 8'(rnd()) & msk[i]);
			acc(0, ofs[i], REG_WDATA_I & msk[i]);
			acc(1, ofs[i], rst[i]);
		end
		$display("masking and read back done");
		repeat (4)
		begin
			x = 24'(rnd());
			x = {{3{x[20]}}, x[20:0]};
			gtest(8'ha1, 4'h8, x, x);
			gtest(8'had, 4'h8, x, x << 1);
			gtest(8'h95, 4'h8, x, $signed(x) >>> 1);
			gtest(8'hac, 4'hd, x, x << 1);
			gtest(8'hae, 4'h3, x, x << 1);
			gtest(8'h00, 4'h8, x, 24'h00_0000);
		end
		gtest(8'hff, 4'h8, 24'h10_0000, 24'h7f_ffff);
		gtest(8'hff, 4'h8, 24'hf0_0000, 24'h80_0000);
		$display("gain done");
		gtest(8'ha1, 4'h8, x, x);
		acc(1, 8'h4b, 8'h10);
		OVLD1_I = 1;
		OVLD2_I = 1;
		smp(x, 24'h00_0000);
		acc(1, 8'h4b, 8'h08);
		smp(x, x);
		OVLD1_I = 0;
		acc(1, 8'h4b, 8'h18);
		smp(x, x);
		OVLD2_I = 0;
		$display("overload mute done");
		// reset in mid-run must bring every register back
		cyc();
		NRST_I = 0;
		repeat (2) cyc();
		NRST_I = 1;
		for (int i = 0; i < 6; i++)
			acc(0, ofs[i], rst[i]);
		$display("second reset done");
		mod_run(6'd5, 2'd2, 1'b0, 40);
		mod_run(6'd63, 2'd0, 1'b1, 300);
		mod_run(6'd9, 2'd1, 1'b0, 30);
		mod_run(6'd9, 2'd3, 1'b0, 30);
		// let the last delayed bit land and be compared
		repeat (2) cyc();
		$display("phase delay done");
		final_report();
	end

	// hang guard
	initial
	begin
		#200000;
		error_cnt++;
		$display("wrong value at %0t: run did not finish", $time);
		final_report();
	end
endmodule

bind acb_bank acb_bank_chk i_acb_bank_chk (.CLK_I, .NRST_I, .REG_ADDR_I,
	.REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .REG_HIT_O, .OVLD1_I,
	.OVLD2_I, .SMP_VALID_I, .SMP_VALID_O, .SMP_O, .MOD_TICK_I, .MOD_STROBE_O,
	.CH2_SILENCE_O, .CIC_ORDER_O, .FIR_SKIP_O, .DEM_DOUBLE_O,
	.LOW_POWER_FILTER_O, .CH1_SOURCE_O, .CH1_COUPLING_O, .CH1_RANGE_O,
	.CH1_BANDWIDTH_O, .CH1_ANA_DELAY_O);
